// ---- src/tph_pkg.sv ----
/*
 Package for the terminal port flow handshake block: register offsets, field
 positions, reset values, strap encodings and timing constants.
 Assumes a 100 MHz system clock and an APB register bus with 32-bit data.
*/
package tph_pkg;

   // System clock rate in hertz.
   localparam int unsigned CLK_HZ = 100_000_000;

   // Register byte offsets on the APB bus.
   localparam logic [7:0] OFF_CTRL   = 8'h00;  // Control word.
   localparam logic [7:0] OFF_FORMAT = 8'h04;  // Character format and rate.
   localparam logic [7:0] OFF_STATUS = 8'h08;  // Line and buffer state.
   localparam logic [7:0] OFF_TXDATA = 8'h0C;  // Transmit data write port.
   localparam logic [7:0] OFF_RXDATA = 8'h10;  // Receive data read port.

   // Control register fields.
   localparam int CTRL_SWFC_TX = 0;  // Software flow control, device to terminal.
   localparam int CTRL_SWFC_RX = 1;  // Software flow control, terminal to device.

   // Format register fields.
   localparam int FMT_LEN8    = 0;  // One selects eight data bits, zero seven.
   localparam int FMT_PAR_LO  = 1;  // Parity field, two bits wide.
   localparam int FMT_PAR_HI  = 2;
   localparam int FMT_RATE_LO = 4;  // Rate select, three bits wide.
   localparam int FMT_RATE_HI = 6;

   // Reset values of the stored parameters.
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [6:0] FMT_RESET  = 7'h35;  // 4800 baud, 8 bits, odd parity.

   // Parity choices.
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;
   localparam logic [1:0] PAR_MARK = 2'h3;

   // Rate select codes.
   localparam logic [2:0] RATE_300   = 3'h0;
   localparam logic [2:0] RATE_1200  = 3'h1;
   localparam logic [2:0] RATE_2400  = 3'h2;
   localparam logic [2:0] RATE_4800  = 3'h3;
   localparam logic [2:0] RATE_9600  = 3'h5;
   localparam logic [2:0] RATE_19200 = 3'h6;

   // Carrier detect strap encodings.
   localparam logic [1:0] CD_FOLLOW = 2'h0;  // Open: follows link connection.
   localparam logic [1:0] CD_ON     = 2'h1;  // Forced on.
   localparam logic [1:0] CD_OFF    = 2'h2;  // Forced off.

   // Software flow control characters.
   localparam logic [7:0] CHAR_XON  = 8'h11;
   localparam logic [7:0] CHAR_XOFF = 8'h13;

   // Receive buffer depth and pointer width.
   localparam int RX_DEPTH = 4;
   localparam int RX_PW    = 2;

   // Bit time divider width.
   localparam int DIV_W = 19;

   // Status word fields.
   localparam int ST_TXBUSY = 0;
   localparam int ST_RXFULL = 1;
   localparam int ST_RXAVL  = 2;
   localparam int ST_CTS    = 3;
   localparam int ST_DTR    = 4;
   localparam int ST_DCD    = 5;
   localparam int ST_RATE19 = 6;
   localparam int ST_PAUSED = 7;
   localparam int ST_FERR   = 8;

   // Serial line configuration carried together.
   typedef struct packed {
      logic       len8;
      logic [1:0] parity;
      logic [DIV_W-1:0] bit_cycles;
   } tph_line_type;

   // Bit time in clock cycles for a baud rate.
   function automatic logic [DIV_W-1:0] baud_cycles(input int unsigned baud);
      baud_cycles = DIV_W'(CLK_HZ / baud);
   endfunction : baud_cycles

endpackage : tph_pkg

// ---- src/tph_serial.sv ----
/*
 Serial character engine for the terminal port: one transmitter and one
 receiver with 7 or 8 data bits, optional parity and one stop bit.
 Assumes the line configuration is steady while characters move.
*/
`timescale 1ns/1ns
module tph_serial (
   // Clock and reset.
   input  wire logic               pclk,
   input  wire logic               presetn,
   // Line configuration.
   input  wire tph_pkg::tph_line_type cfg,
   // Transmit request.
   input  wire logic               tx_valid,
   input  wire logic [7:0]         tx_data,
   output logic                    tx_ready,
   // Receive result.
   output logic                    rx_valid,
   output logic [7:0]              rx_data,
   output logic                    rx_ferr,
   // Serial lines.
   input  wire logic               rxd,
   output logic                    txd
);

   // Parity bit for a character under the given choice.
   function automatic logic par_bit(input logic [7:0] d, input logic l8, input logic [1:0] p);
      logic x;
      x = ^(l8 ? d : {1'b0, d[6:0]});
      unique case (p)
         tph_pkg::PAR_EVEN: par_bit = x;
         tph_pkg::PAR_ODD:  par_bit = ~x;
         tph_pkg::PAR_MARK: par_bit = 1'b1;
         default:           par_bit = 1'b0;
      endcase
   endfunction : par_bit

   logic [10:0]              tx_sh_r;   // Frame bits still to send, low first.
   logic [3:0]               tx_n_r;    // Bits left in the frame.
   logic [tph_pkg::DIV_W-1:0] tx_cnt_r; // Cycles left in the current bit.
   logic [3:0]               frame_len; // Start, data, parity and stop bits.

   // Frame length follows the format.
   always_comb begin
      frame_len = 4'(32'd9 + {31'd0, cfg.len8} + {31'd0, cfg.parity != tph_pkg::PAR_NONE});
   end

   assign tx_ready = (tx_n_r == 4'h0);
   assign txd      = (tx_n_r == 4'h0) ? 1'b1 : tx_sh_r[0];

   // Transmitter: load a frame, then shift one bit per bit time.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_sh_r  <= 11'h7FF;
         tx_n_r   <= 4'h0;
         tx_cnt_r <= '0;
      end else if (tx_n_r == 4'h0) begin
         if (tx_valid) begin
            // Parity and stop are placed right after the last data bit.
            if (cfg.len8)
               tx_sh_r <= (cfg.parity != tph_pkg::PAR_NONE)
                  ? {1'b1, par_bit(tx_data, 1'b1, cfg.parity), tx_data, 1'b0}
                  : {2'b11, tx_data, 1'b0};
            else
               tx_sh_r <= (cfg.parity != tph_pkg::PAR_NONE)
                  ? {2'b11, par_bit(tx_data, 1'b0, cfg.parity), tx_data[6:0], 1'b0}
                  : {3'b111, tx_data[6:0], 1'b0};
            tx_n_r   <= frame_len;
            tx_cnt_r <= cfg.bit_cycles;
         end
      end else if (tx_cnt_r <= 1) begin
         tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
         tx_n_r   <= tx_n_r - 4'h1;
         tx_cnt_r <= cfg.bit_cycles;
      end else begin
         tx_cnt_r <= tx_cnt_r - 1'b1;
      end
   end

   logic [10:0]              rx_sh_r;   // Sampled bits, newest at the top.
   logic [3:0]               rx_n_r;    // Bits left to sample.
   logic [tph_pkg::DIV_W-1:0] rx_cnt_r; // Cycles to the next sample point.
   logic [10:0]              rx_al;     // Frame aligned to bit zero.

   // Right align the captured frame by its length. The bit being sampled now
   // is included, because the shift register only takes it at this edge.
   always_comb begin
      rx_al = {rxd, rx_sh_r[10:1]} >> (4'd11 - frame_len);
   end

   // Receiver: wait for a start edge, sample mid bit, check the stop bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_sh_r  <= '0;
         rx_n_r   <= 4'h0;
         rx_cnt_r <= '0;
         rx_valid <= 1'b0;
         rx_data  <= 8'h00;
         rx_ferr  <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (rx_n_r == 4'h0) begin
            if (!rxd) begin
               rx_n_r   <= frame_len;
               rx_cnt_r <= cfg.bit_cycles >> 1;
            end
         end else if (rx_cnt_r <= 1) begin
            rx_sh_r  <= {rxd, rx_sh_r[10:1]};
            rx_n_r   <= rx_n_r - 4'h1;
            rx_cnt_r <= cfg.bit_cycles;
            if (rx_n_r == 4'h1) begin
               // Last sample is the stop bit; a low stop bit is a framing error.
               rx_valid <= 1'b1;
               rx_ferr  <= ~rxd;
               rx_data  <= cfg.len8 ? rx_al[8:1] : {1'b0, rx_al[7:1]};
            end
         end else begin
            rx_cnt_r <= rx_cnt_r - 1'b1;
         end
      end
   end

endmodule : tph_serial

// ---- src/tph_port.sv ----
/*
 Terminal port with hardware and software flow control, acting as the data
 set end of the link. Holds line configuration registers on APB, drives the
 ready, clear-to-send and carrier-detect lines and obeys terminal ready under hardware flow.
 Assumes straps and handshake inputs are synchronous to pclk and that
 unconnected handshake inputs arrive already pulled to their active level.
*/
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module tph_port (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Terminal lines, all active high at this level.
   input  wire logic        term_rxd,
   output logic             term_txd,
   input  wire logic        term_dtr,
   output logic             term_dsr,
   output logic             term_cts,
   output logic             term_dcd,
   // Straps and link status.
   input  wire logic [1:0]  carrier_detect_strap,
   input  wire logic        terminal_rate_strap,
   input  wire logic        parameter_reset_strap,
   input  wire logic        link_connected
);

   logic [1:0]  ctrl_r;       // Software flow enables, one per direction.
   logic [6:0]  fmt_r;        // Length, parity and rate select.
   logic [7:0]  txhold_r;     // Character waiting to go to the terminal.
   logic        txfull_r;     // Transmit holding register occupied.
   logic        paused_r;     // Terminal sent stop under software flow.
   logic [7:0]  rxbuf_r [tph_pkg::RX_DEPTH];  // Receive storage.
   logic [tph_pkg::RX_PW-1:0] rx_wp_r;        // Receive write index.
   logic [tph_pkg::RX_PW-1:0] rx_rp_r;        // Receive read index.
   logic [tph_pkg::RX_PW:0]   rx_cnt_r;       // Characters held.
   logic        ferr_r;       // Sticky framing error flag.
   logic        rx_full;      // Receive storage has no room.
   logic        wr_acc;       // APB write access phase.
   logic        rd_acc;       // APB read access phase.
   logic        tx_go;        // Transmit engine takes the held character.
   logic        tx_ready;     // Transmit engine idle.
   logic        rx_valid;     // Character arrived from the terminal.
   logic [7:0]  rx_data;      // Arrived character.
   logic        rx_ferr;      // Arrived character had a bad stop bit.
   logic        rx_flow_char; // Arrived character is a flow control code.
   logic        rx_pop;       // Software read of the receive port.
   logic        rx_push;      // Arrived character stored.
   logic        rate_ok;      // Selected rate permitted by the strap.
   tph_pkg::tph_line_type line_cfg;  // Configuration for the engine.

   // Decode helpers for APB offsets.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // Every access completes in its first access cycle.
   assign pready  = 1'b1;
   assign wr_acc  = psel && penable && pwrite;
   assign rd_acc  = psel && penable && !pwrite;
   // Unmapped offsets answer with an error rather than silently passing.
   assign pslverr = psel && penable && !(hit(paddr, tph_pkg::OFF_CTRL)
                    || hit(paddr, tph_pkg::OFF_FORMAT) || hit(paddr, tph_pkg::OFF_STATUS)
                    || hit(paddr, tph_pkg::OFF_TXDATA) || hit(paddr, tph_pkg::OFF_RXDATA));

   // The ready line is never withdrawn while powered.
   assign term_dsr = 1'b1;

   // Configuration registers. The parameter reset strap behaves like a
   // second reset so a stuck configuration can always be recovered.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= tph_pkg::CTRL_RESET;
         fmt_r  <= tph_pkg::FMT_RESET;
      end else if (parameter_reset_strap) begin
         ctrl_r <= tph_pkg::CTRL_RESET;
         fmt_r  <= tph_pkg::FMT_RESET;
      end else if (wr_acc && hit(paddr, tph_pkg::OFF_CTRL)) begin
         // Each direction keeps its own enable bit.
         ctrl_r <= pwdata[tph_pkg::CTRL_SWFC_RX:tph_pkg::CTRL_SWFC_TX];
      end else if (wr_acc && hit(paddr, tph_pkg::OFF_FORMAT)) begin
         fmt_r <= pwdata[tph_pkg::FMT_RATE_HI:tph_pkg::FMT_LEN8];
      end
   end

   // Rate table: only standard rates, and the strap decides whether the
   // slowest or the fastest one is allowed. A forbidden or unknown code
   // falls back to 9600 so the port never runs at an odd rate.
   always_comb begin
      line_cfg.len8   = fmt_r[tph_pkg::FMT_LEN8];
      line_cfg.parity = fmt_r[tph_pkg::FMT_PAR_HI:tph_pkg::FMT_PAR_LO];
      rate_ok         = 1'b1;
      unique case (fmt_r[tph_pkg::FMT_RATE_HI:tph_pkg::FMT_RATE_LO])
         tph_pkg::RATE_300: begin
            rate_ok             = terminal_rate_strap;
            line_cfg.bit_cycles = tph_pkg::baud_cycles(300);
         end
         tph_pkg::RATE_1200:  line_cfg.bit_cycles = tph_pkg::baud_cycles(1200);
         tph_pkg::RATE_2400:  line_cfg.bit_cycles = tph_pkg::baud_cycles(2400);
         tph_pkg::RATE_4800:  line_cfg.bit_cycles = tph_pkg::baud_cycles(4800);
         tph_pkg::RATE_19200: begin
            rate_ok             = !terminal_rate_strap;
            line_cfg.bit_cycles = tph_pkg::baud_cycles(19200);
         end
         default:             line_cfg.bit_cycles = tph_pkg::baud_cycles(9600);
      endcase
      if (!rate_ok) begin
         line_cfg.bit_cycles = tph_pkg::baud_cycles(9600);
      end
   end

   // Outbound gate: hardware flow obeys terminal ready; with software flow
   // the ready line is ignored and a received stop code pauses instead.
   // A terminal that leaves ready unwired reads as ready here.
   assign tx_go = txfull_r && tx_ready && (ctrl_r[tph_pkg::CTRL_SWFC_TX]
                  ? !paused_r
                  : term_dtr);

   // Transmit holding register; a write while full is dropped, which
   // software avoids by polling the busy bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txhold_r <= 8'h00;
         txfull_r <= 1'b0;
      end else if (wr_acc && hit(paddr, tph_pkg::OFF_TXDATA) && !txfull_r) begin
         txhold_r <= pwdata[7:0];
         txfull_r <= 1'b1;
      end else if (tx_go) begin
         txfull_r <= 1'b0;
      end
   end

   // Flow codes are consumed only while software flow is on outbound.
   assign rx_flow_char = ctrl_r[tph_pkg::CTRL_SWFC_TX]
                         && (rx_data == tph_pkg::CHAR_XON || rx_data == tph_pkg::CHAR_XOFF);

   // Pause state from received flow codes; cleared when the mode is off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         paused_r <= 1'b0;
      end else if (!ctrl_r[tph_pkg::CTRL_SWFC_TX]) begin
         paused_r <= 1'b0;
      end else if (rx_valid && rx_flow_char) begin
         paused_r <= (rx_data == tph_pkg::CHAR_XOFF);
      end
   end

   assign rx_full = (rx_cnt_r == 3'(tph_pkg::RX_DEPTH));
   assign rx_pop  = rd_acc && hit(paddr, tph_pkg::OFF_RXDATA) && (rx_cnt_r != '0);
   // A character that arrives with storage full is lost; the terminal is told to stop only
   // by clear-to-send with inbound soft flow off, as no stop code is ever sent.
   assign rx_push = rx_valid && !rx_flow_char && !rx_full;

   // Receive storage write side.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_wp_r <= '0;
      end else if (rx_push) begin
         rx_wp_r <= rx_wp_r + 1'b1;
      end
   end

   // Receive storage data; no reset needed on the storage itself.
   always_ff @(posedge pclk) begin
      if (rx_push) begin
         rxbuf_r[rx_wp_r] <= rx_data;
      end
   end

   // Receive read index and occupancy.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_rp_r  <= '0;
         rx_cnt_r <= '0;
      end else begin
         if (rx_pop) begin
            rx_rp_r <= rx_rp_r + 1'b1;
         end
         rx_cnt_r <= rx_cnt_r + {2'b00, rx_push} - {2'b00, rx_pop};
      end
   end

   // Framing error: a new error wins over a clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ferr_r <= 1'b0;
      end else if (rx_valid && rx_ferr) begin
         ferr_r <= 1'b1;
      end else if (rd_acc && hit(paddr, tph_pkg::OFF_STATUS)) begin
         ferr_r <= 1'b0;
      end
   end

   // Clear-to-send from a register so it never glitches on the line.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         term_cts <= 1'b1;
      end else if (ctrl_r[tph_pkg::CTRL_SWFC_RX]) begin
         term_cts <= 1'b1;
      end else begin
         term_cts <= !rx_full;
      end
   end

   // Carrier detect from the strap; open strap tracks the link.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         term_dcd <= 1'b0;
      end else begin
         unique case (carrier_detect_strap)
            tph_pkg::CD_ON:  term_dcd <= 1'b1;
            tph_pkg::CD_OFF: term_dcd <= 1'b0;
            default:         term_dcd <= link_connected;
         endcase
      end
   end

   // Read data mux, registered as the access phase begins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (hit(paddr, tph_pkg::OFF_CTRL)) begin
            prdata[1:0] <= ctrl_r;
         end else if (hit(paddr, tph_pkg::OFF_FORMAT)) begin
            prdata[6:0] <= fmt_r;
         end else if (hit(paddr, tph_pkg::OFF_STATUS)) begin
            prdata[tph_pkg::ST_TXBUSY] <= txfull_r || !tx_ready;
            prdata[tph_pkg::ST_RXFULL] <= rx_full;
            prdata[tph_pkg::ST_RXAVL]  <= (rx_cnt_r != '0);
            prdata[tph_pkg::ST_CTS]    <= term_cts;
            prdata[tph_pkg::ST_DTR]    <= term_dtr;
            prdata[tph_pkg::ST_DCD]    <= term_dcd;
            prdata[tph_pkg::ST_RATE19] <= !terminal_rate_strap;
            prdata[tph_pkg::ST_PAUSED] <= paused_r;
            prdata[tph_pkg::ST_FERR]   <= ferr_r;
         end else if (hit(paddr, tph_pkg::OFF_RXDATA)) begin
            prdata[7:0] <= rxbuf_r[rx_rp_r];
         end
      end
   end

   // Character engine.
   tph_serial u_serial (
      .pclk     (pclk),
      .presetn  (presetn),
      .cfg      (line_cfg),
      .tx_valid (tx_go),
      .tx_data  (txhold_r),
      .tx_ready (tx_ready),
      .rx_valid (rx_valid),
      .rx_data  (rx_data),
      .rx_ferr  (rx_ferr),
      .rxd      (term_rxd),
      .txd      (term_txd)
   );

endmodule : tph_port

// ---- testbench/tph_port_properties.sv ----
/*
 Checker for the terminal port: line handshake, strap and bus answer relations.
 Assumes it is bound to tph_port and sees only that module's ports.
*/
`timescale 1ns/1ns
module tph_port_properties (
   // Clock, reset and bus.
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Lines and straps.
   input wire logic        term_dsr,
   input wire logic        term_cts,
   input wire logic        term_dcd,
   input wire logic [1:0]  carrier_detect_strap,
   input wire logic        terminal_rate_strap,
   input wire logic        parameter_reset_strap,
   input wire logic        link_connected
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic swfc_rx_r;  // Shadow of the inbound software flow enable.
   logic mapped;     // High when the address names a register.
   assign mapped = paddr inside {tph_pkg::OFF_CTRL, tph_pkg::OFF_FORMAT, tph_pkg::OFF_STATUS,
                                 tph_pkg::OFF_TXDATA, tph_pkg::OFF_RXDATA};
   // The shadow follows bus writes and clears with the strap, as the design must.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         swfc_rx_r <= 1'b0;
      end else if (parameter_reset_strap) begin
         swfc_rx_r <= 1'b0;
      end else if (psel && penable && pwrite && pready && paddr == tph_pkg::OFF_CTRL) begin
         swfc_rx_r <= pwdata[tph_pkg::CTRL_SWFC_RX];
      end
   end
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_stat_rd;
      s_access ##0 (!pwrite && paddr == tph_pkg::OFF_STATUS);
   endsequence
   AST_DSR_ON: assert property (term_dsr)
      else $error("ready line dropped");
   AST_PREADY: assert property (s_access |-> pready)
      else $error("no answer in access cycle");
   AST_SLVERR: assert property (s_access |-> pslverr == !mapped)
      else $error("error answer disagrees with address map");
   AST_CTS_FORCED: assert property (swfc_rx_r && $past(swfc_rx_r) |-> term_cts)
      else $error("clear to send low under inbound soft flow");
   AST_DCD_ON: assert property ($past(presetn) && $past(carrier_detect_strap) == tph_pkg::CD_ON
                                |-> term_dcd)
      else $error("carrier not forced on");
   AST_DCD_OFF: assert property ($past(presetn) && $past(carrier_detect_strap) == tph_pkg::CD_OFF
                                 |-> !term_dcd)
      else $error("carrier not forced off");
   AST_DCD_FOLLOW: assert property ($past(presetn) && $past(carrier_detect_strap) != tph_pkg::CD_ON
      && $past(carrier_detect_strap) != tph_pkg::CD_OFF |-> term_dcd == $past(link_connected))
      else $error("carrier does not follow link");
   AST_RATE19: assert property (s_stat_rd |->
      prdata[tph_pkg::ST_RATE19] == !$past(terminal_rate_strap))
      else $error("fast rate flag disagrees with strap");
endmodule : tph_port_properties
bind tph_port tph_port_properties u_tph_port_properties (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .term_dsr(term_dsr),
   .term_cts(term_cts), .term_dcd(term_dcd), .carrier_detect_strap(carrier_detect_strap),
   .terminal_rate_strap(terminal_rate_strap), .parameter_reset_strap(parameter_reset_strap),
   .link_connected(link_connected));

// ---- testbench/tph_term_model.sv ----
/*
 Terminal model: sends and receives 8N1 characters at a fixed bit time.
 Assumes the port runs at the rate matching BIT and idles its line high.
*/
`timescale 1ns/1ns
module tph_term_model #(
   parameter int BIT = 5208  // Cycles per bit at 19200 baud.
) (
   // Serial lines seen from the terminal.
   input  wire logic pclk,
   input  wire logic term_txd,
   input  wire logic term_cts,
   output logic      term_rxd
);
   initial term_rxd = 1'b1;  // Idle mark level.
   // Sends one character LSB first, only once clear to send is high.
   task send(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      while (term_cts !== 1'b1) @(posedge pclk);
      for (int i = 0; i < 10; i++) begin
         term_rxd <= f[i];
         repeat (BIT) @(posedge pclk);
      end
   endtask : send
   // Receives one character, sampling each bit at its middle.
   task recv(output logic [7:0] c);
      @(negedge term_txd);
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge pclk);
         c[i] = term_txd;
      end
      repeat (BIT) @(posedge pclk);
   endtask : recv
endmodule : tph_term_model

// ---- testbench/terminal_port_flow_handshake_test.sv ----
/*
 Testbench for the terminal port: bus register checks, straps and a duplex character.
 Assumes tph_port, its checker bind and the terminal model are compiled first.
*/
`timescale 1ns/1ns
module terminal_port_flow_handshake_test;
   logic pclk, presetn, psel, penable, pwrite, term_dtr, rate_s, prst_s, link;
   logic [7:0] paddr, got;
   logic [31:0] pwdata, prdata, rd_q;
   logic pready, pslverr, err_q, rxd, txd, dsr, cts, dcd;
   logic [1:0] cd_s;
   logic [1:0] cd_tab [3] = '{tph_pkg::CD_ON, tph_pkg::CD_OFF, tph_pkg::CD_FOLLOW};
   int failures = 0, num_checks = 0, n;
   tph_port u_tph_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .term_rxd(rxd), .term_txd(txd), .term_dtr(term_dtr), .term_dsr(dsr),
      .term_cts(cts), .term_dcd(dcd), .carrier_detect_strap(cd_s),
      .terminal_rate_strap(rate_s), .parameter_reset_strap(prst_s), .link_connected(link));
   tph_term_model u_tph_term_model (.pclk(pclk), .term_txd(txd), .term_cts(cts),
      .term_rxd(rxd));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // One APB transfer; read data and error are taken at the ready edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task summarize;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // A hang is cut short at 90k cycles, past the expected run of about 52k cycles.
   initial begin
      #900_000;
      failures++;
      summarize();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {term_dtr, rate_s, prst_s, link, cd_s} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, tph_pkg::OFF_CTRL, 32'h0);
      chk("ctrl reset", 32'h0, rd_q);
      apb(1'b0, tph_pkg::OFF_FORMAT, 32'h0);
      chk("format reset", 32'h35, rd_q);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped", 32'h1, 32'(err_q));
      // Each enable is written alone and read back alone.
      apb(1'b1, tph_pkg::OFF_CTRL, 32'h2);
      apb(1'b0, tph_pkg::OFF_CTRL, 32'h0);
      chk("ctrl in only", 32'h2, rd_q);
      chk("cts forced", 32'h1, 32'(cts));
      apb(1'b1, tph_pkg::OFF_CTRL, 32'h1);
      apb(1'b1, tph_pkg::OFF_FORMAT, 32'h2B);
      apb(1'b0, tph_pkg::OFF_CTRL, 32'h0);
      chk("ctrl out only", 32'h1, rd_q);
      @(posedge pclk) prst_s <= 1'b1;
      @(posedge pclk) prst_s <= 1'b0;
      apb(1'b0, tph_pkg::OFF_CTRL, 32'h0);
      chk("ctrl strap", 32'h0, rd_q);
      apb(1'b0, tph_pkg::OFF_FORMAT, 32'h0);
      chk("format strap", 32'h35, rd_q);
      for (int k = 1; k >= 0; k--) begin
         rate_s <= k[0];
         apb(1'b0, tph_pkg::OFF_STATUS, 32'h0);
         chk("rate19 flag", 32'(k == 0), 32'(rd_q[tph_pkg::ST_RATE19]));
      end
      link <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         cd_s <= cd_tab[k];
         repeat (3) @(posedge pclk);
         chk("carrier", 32'(k != 1), 32'(dcd));
      end
      // A character waits while the terminal is not ready, then crosses both ways.
      apb(1'b1, tph_pkg::OFF_FORMAT, 32'h61);
      apb(1'b1, tph_pkg::OFF_TXDATA, 32'hA5);
      repeat (50) @(posedge pclk);
      chk("txd held", 32'h1, 32'(txd));
      term_dtr <= 1'b1;
      fork
         u_tph_term_model.recv(got);
         u_tph_term_model.send(8'h3C);
      join
      chk("char out", 32'hA5, 32'(got));
      apb(1'b0, tph_pkg::OFF_STATUS, 32'h0);
      chk("rx avail", 32'h1, 32'(rd_q[tph_pkg::ST_RXAVL]));
      apb(1'b0, tph_pkg::OFF_RXDATA, 32'h0);
      chk("char in", 32'h3C, rd_q & 32'hFF);
      chk("cts after pop", 32'h1, 32'(cts));
      // Outbound soft flow starts a character with the terminal not ready.
      apb(1'b1, tph_pkg::OFF_CTRL, 32'h1);
      term_dtr <= 1'b0;
      apb(1'b1, tph_pkg::OFF_TXDATA, 32'h5A);
      n = 0;
      while (txd === 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk("start ignores dtr", 32'h0, 32'(txd));
      chk("dsr", 32'h1, 32'(dsr));
      summarize();
   end
endmodule : terminal_port_flow_handshake_test
